// ==== charger_alert_status_regs.v ====
// Charger alert flags and live status behind a two-wire serial slave.
//
// Contract
// - Set phase bit 7 on entering low-voltage conditioning.
// - Set phase bit 6 on entering the main charge phase.
// - Set bits 5, 4, 3 on thermistor hold, timeout and taper end.
// - Set phase bit 2 on the overtime fault state.
// - Set bit 1 on missing pack, bit 0 on shorted pack.
// - Host writes 0 to clear a bit; only zero-written bits clear.
// - Clearing an enable bit also clears its latched alert.
// - Six loop flags at 0x38, masked, sticky until cleared or disabled.
// - Set loop bit 5 on current limit, bit 4 on thermal regulation.
// - Set loop bit 3 on input sag limit, bit 2 on input current.
// - Set loop bit 1 on constant current, bit 0 on constant voltage.
// - Live register at 0x39, nine bits, read-only, not latched.
// - Live bit 8 is high whenever the charger is active.
// - Stack pins coding more than eight cells flag error, stop charge.
// - Stack size error reads true while telemetry is disabled.
// - Each phase flag latches only while its mask bit is set.
`timescale 1ns/10ps
`include "charger_alert_defs.vh"
module charger_alert_status_regs (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [7:0] phase_condition,
  input wire [5:0] loop_state_indicator,
  input wire charger_active,
  input wire telemetry_enabled,
  input wire [1:0] stack_select_pin_a,
  input wire [1:0] stack_select_pin_b,
  output reg charge_inhibit
);

  localparam ST_IDLE = 5'h01;
  localparam ST_RX = 5'h02;
  localparam ST_ACK = 5'h04;
  localparam ST_TX = 5'h08;
  localparam ST_RACK = 5'h10;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  reg scl_s1;
  reg scl_s2;
  reg scl_d;
  reg sda_s1;
  reg sda_s2;
  reg sda_d;
  reg [3:0] stack_s1;
  reg [3:0] stack_s2;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      stack_s1 <= 4'h0;
      stack_s2 <= 4'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      stack_s1 <= {stack_select_pin_a, stack_select_pin_b};
      stack_s2 <= stack_s1;
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  //////////////////////////////////////////////////////////////////////////
  // Stack size decode and live condition.

  // Each select pin is read as low, open or high (codes 0, 1, 2); code 3
  // cannot come from a three-level detector and is taken as high.
  function [3:0] stack_cells;
    input [1:0] pin_a;
    input [1:0] pin_b;
    reg [1:0] a;
    reg [1:0] b;
    begin
      a = (pin_a == 2'h3) ? 2'h2 : pin_a;
      b = (pin_b == 2'h3) ? 2'h2 : pin_b;
      stack_cells = {2'h0, a} + {2'h0, a} + {2'h0, a} + {2'h0, b} + 4'h1;
    end
  endfunction

  wire stack_too_big;
  wire stack_size_error;
  wire [8:0] live_condition;

  assign stack_too_big =
    stack_cells(stack_s2[3:2], stack_s2[1:0]) > `MAX_STACK_CELLS;
  assign stack_size_error = stack_too_big | ~telemetry_enabled;
  // Remaining live bits are outside this block and read as zero.
  assign live_condition =
    {charger_active, stack_size_error, 7'h00};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_inhibit <= 1'b0;
    end else begin
      charge_inhibit <= stack_too_big;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Enable registers and alert banks.

  reg [7:0] phase_mask;
  reg [5:0] loop_mask;
  reg wr_stb;
  reg [7:0] wr_cmd;
  reg [15:0] wr_data;
  wire [7:0] phase_flags;
  wire [5:0] loop_flags;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_mask <= `PHASE_MASK_RESET;
      loop_mask <= `LOOP_MASK_RESET;
    end else if (wr_stb) begin
      // Dropping an enable here empties its flag in the bank.
      if (wr_cmd == `PHASE_MASK_REG_ADDR)
        phase_mask <= wr_data[7:0];
      if (wr_cmd == `LOOP_MASK_REG_ADDR)
        loop_mask <= wr_data[5:0];
    end
  end

  // Phase conditions arrive already one bit per documented position.
  alert_latch_bank #(
    .WIDTH(`PHASE_FLAG_WIDTH)
  ) phase_bank (
    .clk(clk),
    .rst_n(rst_n),
    .cond(phase_condition),
    .enable(phase_mask),
    .clr_stb(wr_stb && wr_cmd == `PHASE_FLAG_REG_ADDR),
    .clr_data(wr_data[7:0]),
    .flags(phase_flags)
  );

  alert_latch_bank #(
    .WIDTH(`LOOP_FLAG_WIDTH)
  ) loop_bank (
    .clk(clk),
    .rst_n(rst_n),
    .cond(loop_state_indicator),
    .enable(loop_mask),
    .clr_stb(wr_stb && wr_cmd == `LOOP_FLAG_REG_ADDR),
    .clr_data(wr_data[5:0]),
    .flags(loop_flags)
  );

  // Read data has no side effect on any flag.
  function [15:0] read_value;
    input [7:0] code;
    begin
      case (code)
        `PHASE_FLAG_REG_ADDR: read_value = {8'h00, phase_flags};
        `LOOP_FLAG_REG_ADDR: read_value = {10'h000, loop_flags};
        `LIVE_COND_REG_ADDR: read_value = {7'h00, live_condition};
        `PHASE_MASK_REG_ADDR: read_value = {8'h00, phase_mask};
        `LOOP_MASK_REG_ADDR: read_value = {10'h000, loop_mask};
        default: read_value = 16'h0000;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Two-wire slave: word writes and word reads, low byte first.

  reg [4:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shreg;
  reg byte_full;
  reg [1:0] byte_idx;
  reg rw;
  reg [7:0] cmd;
  reg [7:0] wr_lo;
  reg [15:0] rd_word;
  reg rack_ok;
  reg hi_sent;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      byte_full <= 1'b0;
      byte_idx <= 2'h0;
      rw <= 1'b0;
      cmd <= 8'h00;
      wr_lo <= 8'h00;
      rd_word <= 16'h0000;
      rack_ok <= 1'b0;
      hi_sent <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      wr_stb <= 1'b0;
      wr_cmd <= 8'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      if (bus_start) begin
        state <= ST_RX;
        bit_cnt <= 3'h0;
        byte_full <= 1'b0;
        byte_idx <= 2'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
                byte_full <= 1'b1;
            end else if (scl_fall && byte_full) begin
              byte_full <= 1'b0;
              state <= ST_ACK;
              sda_oe <= 1'b1;
              byte_idx <= byte_idx + 2'h1;
              case (byte_idx)
                2'h0: begin
                  if (shreg[7:1] != `SERIAL_DEV_ADDR) begin
                    // Not our address: stay off the bus until the next start.
                    state <= ST_IDLE;
                    sda_oe <= 1'b0;
                  end
                  rw <= shreg[0];
                  rd_word <= read_value(cmd);
                end
                2'h1: cmd <= shreg;
                2'h2: wr_lo <= shreg;
                default: begin
                  wr_stb <= 1'b1;
                  wr_cmd <= cmd;
                  wr_data <= {shreg, wr_lo};
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (rw) begin
                state <= ST_TX;
                shreg <= rd_word[7:0];
                sda_oe <= ~rd_word[7];
                hi_sent <= 1'b0;
              end else if (byte_idx == 2'h0) begin
                // A third data byte is not part of a word write.
                state <= ST_IDLE;
                sda_oe <= 1'b0;
              end else begin
                state <= ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 3'h7) begin
                state <= ST_RACK;
                sda_oe <= 1'b0;
                bit_cnt <= 3'h0;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                bit_cnt <= bit_cnt + 3'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rack_ok <= ~sda_s2;
            end else if (scl_fall) begin
              if (rack_ok && !hi_sent) begin
                state <= ST_TX;
                shreg <= rd_word[15:8];
                sda_oe <= ~rd_word[15];
                hi_sent <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ==== charger_alert_defs.vh ====
// Register offsets, field positions and reset values of the alert block.
`ifndef CHARGER_ALERT_DEFS_VH
`define CHARGER_ALERT_DEFS_VH

// Command codes seen by the two-wire host.
`define PHASE_FLAG_REG_ADDR 8'h37
`define LOOP_FLAG_REG_ADDR 8'h38
`define LIVE_COND_REG_ADDR 8'h39
`define PHASE_MASK_REG_ADDR 8'h1c
`define LOOP_MASK_REG_ADDR 8'h1d

// Register widths.
`define PHASE_FLAG_WIDTH 8
`define LOOP_FLAG_WIDTH 6
`define LIVE_COND_WIDTH 9

// Phase flag positions.
`define LOW_VOLT_CONDITIONING_BIT 7
`define MAIN_CHARGE_PHASE_BIT 6
`define THERMISTOR_HOLD_BIT 5
`define TIMEOUT_DONE_BIT 4
`define TAPER_DONE_BIT 3
`define OVERTIME_FAULT_BIT 2
`define PACK_ABSENT_BIT 1
`define PACK_SHORTED_BIT 0

// Regulation loop flag positions.
`define CURRENT_CAP_LOOP_BIT 5
`define HEAT_LOOP_BIT 4
`define SUPPLY_SAG_LOOP_BIT 3
`define SOURCE_DRAW_LOOP_BIT 2
`define FIXED_AMPS_LOOP_BIT 1
`define FIXED_VOLTS_LOOP_BIT 0

// Live condition positions.
`define CHARGER_RUNNING_BIT 8
`define STACK_SIZE_ERROR_BIT 7

// Reset values.
`define PHASE_FLAG_RESET 8'h00
`define LOOP_FLAG_RESET 6'h00
`define PHASE_MASK_RESET 8'h00
`define LOOP_MASK_RESET 6'h00

// Largest cell stack that may be charged.
`define MAX_STACK_CELLS 4'h8

// Serial device address; the value is arbitrary.
`define SERIAL_DEV_ADDR 7'h2a

`endif

// ==== alert_latch_bank.v ====
// Bank of sticky alert flags gated by per-bit enables.
`timescale 1ns/10ps
module alert_latch_bank #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] cond,
  input wire [WIDTH-1:0] enable,
  input wire clr_stb,
  input wire [WIDTH-1:0] clr_data,
  output reg [WIDTH-1:0] flags
);

  wire [WIDTH-1:0] clear_bits;
  wire [WIDTH-1:0] next_flags;

  // Only bits written as 0 are cleared by a host write.
  assign clear_bits = clr_stb ? ~clr_data : {WIDTH{1'b0}};
  // A flag keeps only while enabled, and a live condition wins over a
  // same-cycle clear so no event is lost.
  assign next_flags = (flags & ~clear_bits & enable) |
    (cond & enable);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= {WIDTH{1'b0}};
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ==== charger_alert_monitor.sv ====
// Port-level checks on the alert block's serial pin and charge inhibit.
`timescale 1ns/10ps
module charger_alert_monitor (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [7:0] phase_condition,
  input wire [5:0] loop_state_indicator,
  input wire charger_active,
  input wire telemetry_enabled,
  input wire [1:0] stack_select_pin_a,
  input wire [1:0] stack_select_pin_b,
  input wire charge_inhibit
);
  // More than eight cells needs both pins coded high.
  wire big = stack_select_pin_a[1] & stack_select_pin_b[1];
  reg [5:0] hi_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      hi_cnt <= 6'h00;
    else
      hi_cnt <= scl_in ? hi_cnt + {5'h00, ~&hi_cnt} : 6'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pull; sda_out == 1'b0; endproperty
  property p_inh_set; big [*6] |-> charge_inhibit; endproperty
  property p_inh_clr; !big [*6] |-> !charge_inhibit; endproperty
  property p_stand; $rose(scl_in) |-> $stable(sda_oe) [*8]; endproperty
  property p_oe_on; $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2); endproperty
  property p_oe_off; $fell(sda_oe) |-> !scl_in; endproperty
  property p_idle; hi_cnt == 6'h3f |-> !sda_oe; endproperty
  property p_exit; $rose(rst_n) |-> !sda_oe && !charge_inhibit; endproperty
  a_pull: assert property (p_pull) else $error("sda high");
  a_inh_set: assert property (p_inh_set) else $error("no inhibit");
  a_inh_clr: assert property (p_inh_clr) else $error("inhibit");
  a_stand: assert property (p_stand) else $error("oe moved");
  a_oe_on: assert property (p_oe_on) else $error("oe on early");
  a_oe_off: assert property (p_oe_off) else $error("oe off late");
  a_idle: assert property (p_idle) else $error("oe idle");
  a_exit: assert property (p_exit) else $error("reset value");
  c_inh: cover property ($rose(charge_inhibit));
  c_ack: cover property ($rose(sda_oe));
  c_idle: cover property (hi_cnt == 6'h3f);
endmodule

// ==== smbus_host_model.sv ====
// Two-wire host that writes and reads words of the alert block.
`timescale 1ns/10ps
`include "charger_alert_defs.vh"
module smbus_host_model (
  input wire clk,
  input wire sda_oe,
  input wire sda_out,
  output wire scl,
  output wire sda
);
  reg sc = 1'b1;
  reg hd = 1'b1;
  // Address and write bytes that the device left unacknowledged.
  reg [15:0] nacks = 16'h0000;
  assign scl = sc;
  // Pull-up: the line sits high unless some side pulls it low.
  assign sda = hd & ~(sda_oe & ~sda_out);
  // Data moves while the clock is low; a and b differ for start and stop.
  task step(input a, input b, output r);
    begin
      sc <= 1'b0;
      repeat (4) @(posedge clk);
      hd <= a;
      repeat (4) @(posedge clk);
      sc <= 1'b1;
      repeat (4) @(posedge clk);
      r = sda;
      hd <= b;
      repeat (4) @(posedge clk);
    end
  endtask
  task xbyte(input [7:0] d, input m, output [7:0] q, output k);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        step(d[i], d[i], r);
        q[i] = r;
      end
      step(m, m, k);
    end
  endtask
  task xfer(input rdn, input [7:0] cmd, input [15:0] wi, output [15:0] wo);
    reg [7:0] q;
    reg r;
    reg k;
    begin
      step(1'b1, 1'b0, r);
      xbyte({`SERIAL_DEV_ADDR, 1'b0}, 1'b1, q, k);
      nacks = nacks + {15'h0000, k};
      xbyte(cmd, 1'b1, q, k);
      nacks = nacks + {15'h0000, k};
      if (rdn) begin
        step(1'b1, 1'b0, r);
        xbyte({`SERIAL_DEV_ADDR, 1'b1}, 1'b1, q, k);
        nacks = nacks + {15'h0000, k};
        xbyte(8'hff, 1'b0, wo[7:0], k);
        xbyte(8'hff, 1'b1, wo[15:8], k);
      end else begin
        xbyte(wi[7:0], 1'b1, q, k);
        nacks = nacks + {15'h0000, k};
        xbyte(wi[15:8], 1'b1, q, k);
        nacks = nacks + {15'h0000, k};
      end
      step(1'b0, 1'b1, r);
    end
  endtask
endmodule

// ==== charger_alert_status_regs_tb.sv ====
// Self-checking bench for the charger alert and status registers.
`timescale 1ns/10ps
module charger_alert_status_regs_tb;
  reg clk, rst_n, charger_active, telemetry_enabled;
  reg [7:0] phase_condition;
  reg [5:0] loop_state_indicator;
  reg [1:0] stack_select_pin_a, stack_select_pin_b;
  wire scl_in, sda_in, sda_out, sda_oe, charge_inhibit;
  integer fail_count, n_tests, i;
  reg [15:0] w;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  charger_alert_status_regs dut (.clk, .rst_n, .scl_in, .sda_in, .sda_out,
    .sda_oe, .phase_condition, .loop_state_indicator, .charger_active,
    .telemetry_enabled, .stack_select_pin_a, .stack_select_pin_b,
    .charge_inhibit);
  smbus_host_model host (.clk, .sda_oe, .sda_out, .scl(scl_in),
    .sda(sda_in));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task rc(input [7:0] cmd, input [15:0] exp);
    begin
      host.xfer(1'b1, cmd, 16'h0000, w);
      chk(w, exp);
    end
  endtask
  task pulse(input [7:0] p, input [5:0] l);
    begin
      phase_condition <= p;
      loop_state_indicator <= l;
      @(posedge clk);
      phase_condition <= 8'h00;
      loop_state_indicator <= 6'h00;
      @(posedge clk);
    end
  endtask
  task tally_and_finish;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    fail_count = 0;
    n_tests = 0;
    {rst_n, charger_active, telemetry_enabled} = 3'h1;
    {phase_condition, loop_state_indicator} = 14'h0000;
    {stack_select_pin_a, stack_select_pin_b} = 4'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(8'hff, 6'h3f);
    rc(8'h37, 16'h0000);
    rc(8'h38, 16'h0000);
    host.xfer(1'b0, 8'h1c, 16'h00ff, w);
    host.xfer(1'b0, 8'h1d, 16'h003f, w);
    for (i = 0; i < 8; i = i + 1) begin
      pulse(8'h01 << i, (i < 6) ? 6'h01 << i : 6'h00);
      rc(8'h37, 16'h1 << i);
      rc(8'h38, (i < 6) ? 16'h1 << i : 16'h0);
      host.xfer(1'b0, 8'h37, 16'hff00, w);
      host.xfer(1'b0, 8'h38, 16'hffc0, w);
    end
    pulse(8'hff, 6'h3f);
    host.xfer(1'b0, 8'h37, 16'hfff7, w);
    rc(8'h37, 16'h00f7);
    host.xfer(1'b0, 8'h1c, 16'h007f, w);
    rc(8'h37, 16'h0077);
    pulse(8'h80, 6'h00);
    rc(8'h37, 16'h0077);
    phase_condition <= 8'h01;
    host.xfer(1'b0, 8'h37, 16'hfffe, w);
    phase_condition <= 8'h00;
    rc(8'h37, 16'h0077);
    host.xfer(1'b0, 8'h38, 16'hfffe, w);
    host.xfer(1'b0, 8'h1d, 16'h003d, w);
    rc(8'h38, 16'h003c);
    rc(8'h1c, 16'h007f);
    rc(8'h1d, 16'h003d);
    // A reset in mid-run must empty both flag banks and the phase enable with the bus idle.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rc(8'h37, 16'h0000);
    rc(8'h38, 16'h0000);
    rc(8'h1c, 16'h0000);
    rc(8'h20, 16'h0000);
    charger_active <= 1'b1;
    repeat (70) @(posedge clk);
    rc(8'h39, 16'h0100);
    telemetry_enabled <= 1'b0;
    rc(8'h39, 16'h0180);
    {telemetry_enabled, charger_active} <= 2'h2;
    {stack_select_pin_a, stack_select_pin_b} <= 4'h9;
    rc(8'h39, 16'h0000);
    chk({15'h0000, charge_inhibit}, 16'h0000);
    stack_select_pin_b <= 2'h2;
    host.xfer(1'b0, 8'h39, 16'h0000, w);
    rc(8'h39, 16'h0080);
    chk({15'h0000, charge_inhibit}, 16'h0001);
    chk(host.nacks, 16'h0000);
    tally_and_finish;
  end
endmodule
bind charger_alert_status_regs charger_alert_monitor mon (.clk, .rst_n,
  .scl_in, .sda_in, .sda_out, .sda_oe, .phase_condition,
  .loop_state_indicator, .charger_active, .telemetry_enabled,
  .stack_select_pin_a, .stack_select_pin_b, .charge_inhibit);
